// ---- core/tbc_consts.svh ----
`ifndef TBC_CONSTS_SVH
`define TBC_CONSTS_SVH

// Input type that hands the chain over to the script value
`define TBC_TYPE_SCRIPT     3'h5
// Main sequencer states in which a drive request may pass
`define TBC_MAIN_RUN_A      4'h5
`define TBC_MAIN_RUN_B      4'ha
// Gain reset value and the fixed divide in the multiply stage
`define TBC_GAIN_DEFAULT    16'sh0080
`define TBC_GAIN_SHIFT      7
// Saturation limits
`define TBC_S16_MAX         16'sh7fff
`define TBC_S16_MIN         16'sh8000
`define TBC_POS_MAX         16'sh7fff
// Direction nudge values
`define TBC_NUDGE_FWD       16'sh0001
`define TBC_NUDGE_REV       16'shffff
// Wiring styles of the pot scaler
`define TBC_WIRE_ONE        2'h0
`define TBC_WIRE_TWO        2'h1
`define TBC_WIRE_THREE      2'h2

`endif

// ---- core/tbc_pkg.sv ----
package tbc_pkg;

	// Script-writable values
	typedef struct packed {
		logic signed [15:0] gain;
		logic signed [15:0] bias;
		logic signed [15:0] accel;
		logic signed [15:0] brake;
	} tbc_script_t;

	// Observed values of the chain
	typedef struct packed {
		logic signed [15:0] accel_cmd;
		logic signed [15:0] brake_cmd;
		logic signed [15:0] shaped_accel;
		logic signed [15:0] shaped_brake;
		logic signed [15:0] mapped_accel;
		logic signed [15:0] mapped_decel;
		logic [15:0]        accel_pot_out;
		logic [15:0]        brake_pot_out;
		logic               motor_drive;
	} tbc_obs_t;

endpackage

// ---- core/tbc_path.sv ----
`timescale 1ns/1ps
`include "tbc_consts.svh"
// What this block does
// - Acceleration raw command is a 16-bit magnitude from input type and wiper.
// - Mapped accel exactly zero becomes +1 forward or -1 reverse.
// - Accel type 5 uses the script acceleration value instead.
// - Accel types 1-4 ignore the script value and pass mapped value.
// - Multiply by gain, divide by 128, then add bias.
// - Gain defaults to 128, a pass-through.
// - Gain and bias are signed.
// - Pump mode clamps shaped acceleration to non-negative.
// - Interlock off, fault, or main state not 5/10 zeroes accel request.
// - Motor drives only when absolute accel request exceeds 1.
// - Brake value is signed 16-bit from brake type and wiper.
// - Brake type 5 takes the script brake value.
// - Brake types 1-4 ignore script brake value and pass mapped brake.
// - Brake value saturates to 0 through 32767.
// - Brake path off forces brake request zero, else passes shaped brake.
// - Speed modes zero accel request while brake request is non-zero.
// - Firmware-mapped accel value is exposed to script readers.
// - Type 5 pot output stays zero until pot setup is done.
// - Pot position 0-100% is 0-32767, rescaled per wiring style.
module tbc_path #(
	parameter int ADC_W = 12
) (
	input  wire logic                clk_sys,
	input  wire logic                rst,
	input  wire logic                tick,
	input  wire logic [2:0]          accel_type,
	input  wire logic [2:0]          brake_type,
	input  wire logic [ADC_W-1:0]    accel_wiper_sample,
	input  wire logic [ADC_W-1:0]    brake_wiper_sample,
	input  wire logic [ADC_W-1:0]    pot_low_sample,
	input  wire logic [1:0]          accel_wiring,
	input  wire logic [1:0]          brake_wiring,
	input  wire logic                accel_pot_setup,
	input  wire logic                brake_pot_setup,
	input  wire logic signed [15:0]  accel_map_value,
	input  wire logic signed [15:0]  brake_map_value,
	input  wire logic                fwd_switch,
	input  wire logic                rev_switch,
	input  wire logic                pump_mode,
	input  wire logic                interlock_on,
	input  wire logic                fault_zero_accel,
	input  wire logic [3:0]          main_state,
	input  wire logic                brake_path_on,
	input  wire logic                speed_mode,
	input  wire logic                wr_gain,
	input  wire logic                wr_bias,
	input  wire logic                wr_accel,
	input  wire logic                wr_brake,
	input  wire logic signed [15:0]  wr_data,
	output tbc_pkg::tbc_script_t     script_regs,
	output tbc_pkg::tbc_obs_t        obs,
	output logic [15:0]              accel_raw_cmd,
	output logic signed [15:0]       brake_raw_value
);

	// Script values: only these are writable from outside
	logic signed [15:0] gain_reg;
	logic signed [15:0] gain_next;
	logic signed [15:0] bias_reg;
	logic signed [15:0] bias_next;
	logic signed [15:0] sacc_reg;
	logic signed [15:0] sacc_next;
	logic signed [15:0] sbrk_reg;
	logic signed [15:0] sbrk_next;

	// Next gain; signed, so a negative gain reverses the request
	always_comb begin
		gain_next = gain_reg;
		if (wr_gain) begin
			gain_next = wr_data;
		end
	end

	// Gain register, default is a pass-through multiply
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			gain_reg <= `TBC_GAIN_DEFAULT;
		end else begin
			gain_reg <= gain_next;
		end
	end

	// Next bias; signed offset added after the divide
	always_comb begin
		bias_next = bias_reg;
		if (wr_bias) begin
			bias_next = wr_data;
		end
	end

	// Bias register
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			bias_reg <= 16'sh0000;
		end else begin
			bias_reg <= bias_next;
		end
	end

	// Next script acceleration value
	always_comb begin
		sacc_next = sacc_reg;
		if (wr_accel) begin
			sacc_next = wr_data;
		end
	end

	// Script acceleration register
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sacc_reg <= 16'sh0000;
		end else begin
			sacc_reg <= sacc_next;
		end
	end

	// Next script brake value
	always_comb begin
		sbrk_next = sbrk_reg;
		if (wr_brake) begin
			sbrk_next = wr_data;
		end
	end

	// Script brake register
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sbrk_reg <= 16'sh0000;
		end else begin
			sbrk_reg <= sbrk_next;
		end
	end

	// Pot pin synchronisers, two flip-flops per pin
	logic [ADC_W-1:0]   acc_s1_reg;
	logic [ADC_W-1:0]   acc_s2_reg;
	logic [ADC_W-1:0]   brk_s1_reg;
	logic [ADC_W-1:0]   brk_s2_reg;
	logic [ADC_W-1:0]   low_s1_reg;
	logic [ADC_W-1:0]   low_s2_reg;

	// Accelerator wiper; stage one feeds only stage two
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			acc_s1_reg <= '0;
			acc_s2_reg <= '0;
		end else begin
			acc_s1_reg <= accel_wiper_sample;
			acc_s2_reg <= acc_s1_reg;
		end
	end

	// Brake wiper; stage one feeds only stage two
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			brk_s1_reg <= '0;
			brk_s2_reg <= '0;
		end else begin
			brk_s1_reg <= brake_wiper_sample;
			brk_s2_reg <= brk_s1_reg;
		end
	end

	// Pot low return; stage one feeds only stage two
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			low_s1_reg <= '0;
			low_s2_reg <= '0;
		end else begin
			low_s1_reg <= pot_low_sample;
			low_s2_reg <= low_s1_reg;
		end
	end

	// Rescale a sample to 0..32767 by wiring style
	function automatic logic [15:0] pot_scale(input logic [ADC_W-1:0] w, input logic [ADC_W-1:0] lo,
						  input logic [1:0] style);
		logic [ADC_W-1:0] d;
		logic [15:0]      s;
		d = w;
		if (style == `TBC_WIRE_THREE) begin
			d = (w > lo) ? ADC_W'(w - lo) : '0;
		end
		s = 16'(({16'h0000, d} << 15) >> ADC_W);
		if (style == `TBC_WIRE_TWO) begin
			s = 16'h7fff - s; // Rheostat reads high at rest
		end
		return s;
	endfunction

	// Saturate a 32-bit signed value into signed 16
	function automatic logic signed [15:0] sat16(input logic signed [31:0] v);
		if (v > 32'sd32767) begin
			return `TBC_S16_MAX;
		end else if (v < -32'sd32768) begin
			return `TBC_S16_MIN;
		end
		return v[15:0];
	endfunction

	// Datapath outputs
	tbc_pkg::tbc_obs_t  obs_reg;
	tbc_pkg::tbc_obs_t  obs_next;
	logic [15:0]        raw_reg;
	logic [15:0]        raw_next;
	logic signed [15:0] braw_reg;
	logic signed [15:0] braw_next;

	// Chain intermediate values, all combinational
	logic [15:0]        a_scaled;
	logic [15:0]        b_scaled;
	logic               a_script;
	logic               b_script;
	logic signed [15:0] mapped;
	logic signed [15:0] sel;
	logic signed [31:0] prod;
	logic signed [31:0] sum;
	logic signed [15:0] shaped;
	logic signed [15:0] bsel;
	logic signed [15:0] bshaped;
	logic signed [15:0] bcmd;
	logic               run_state;
	logic               accel_block;
	logic signed [15:0] acmd;
	logic               drive;

	// Pot scaling from the synchronised samples
	always_comb begin
		a_scaled = pot_scale(acc_s2_reg, low_s2_reg, accel_wiring);
		b_scaled = pot_scale(brk_s2_reg, low_s2_reg, brake_wiring);
		a_script = (accel_type == `TBC_TYPE_SCRIPT);
		b_script = (brake_type == `TBC_TYPE_SCRIPT);
	end

	// Direction nudge on a zero mapped value
	always_comb begin
		mapped = accel_map_value;
		if (mapped == 16'sh0000) begin
			if (fwd_switch) begin
				mapped = `TBC_NUDGE_FWD;
			end else if (rev_switch) begin
				mapped = `TBC_NUDGE_REV;
			end
		end
	end

	// Source select, then gain, divide and bias
	always_comb begin
		sel  = a_script ? sacc_reg : mapped;
		prod = (32'(sel) * 32'(gain_reg)) >>> `TBC_GAIN_SHIFT;
		sum  = prod + 32'(bias_reg);
	end

	// Saturate rather than wrap, then clamp reverse away in pump mode
	always_comb begin
		shaped = sat16(sum);
		if (pump_mode && shaped < 16'sh0000) begin
			shaped = 16'sh0000;
		end
	end

	// Brake source select, limiter and enable switch
	always_comb begin
		bsel    = b_script ? sbrk_reg : brake_map_value;
		bshaped = bsel;
		if (bsel < 16'sh0000) begin
			bshaped = 16'sh0000;
		end
		bcmd = brake_path_on ? bshaped : 16'sh0000;
	end

	// Final request gating; a brake request wins in speed modes
	always_comb begin
		run_state   = (main_state == `TBC_MAIN_RUN_A) || (main_state == `TBC_MAIN_RUN_B);
		accel_block = !interlock_on || fault_zero_accel || !run_state;
		acmd        = shaped;
		if (accel_block) begin
			acmd = 16'sh0000;
		end
		if (speed_mode && bcmd != 16'sh0000) begin
			acmd = 16'sh0000;
		end
	end

	// Motor drive decision on the request magnitude
	always_comb begin
		drive = (acmd > 16'sh0001) || (acmd < -16'sh0001);
	end

	// Next raw values, loaded only on the update tick
	always_comb begin
		raw_next  = raw_reg;
		braw_next = braw_reg;
		if (tick) begin
			raw_next  = a_script ? 16'h0000 : a_scaled;
			braw_next = b_script ? 16'sh0000 : $signed(b_scaled);
		end
	end

	// Next observed values, loaded only on the update tick
	always_comb begin
		obs_next = obs_reg;
		if (tick) begin
			obs_next.accel_pot_out = (a_script && !accel_pot_setup) ? 16'h0000 : a_scaled;
			obs_next.brake_pot_out = (b_script && !brake_pot_setup) ? 16'h0000 : b_scaled;
			obs_next.mapped_accel  = accel_map_value;
			obs_next.mapped_decel  = brake_map_value;
			obs_next.shaped_accel  = shaped;
			obs_next.shaped_brake  = bshaped;
			obs_next.brake_cmd     = bcmd;
			obs_next.accel_cmd     = acmd;
			obs_next.motor_drive   = drive;
		end
	end

	// Observation registers
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			obs_reg <= '0;
		end else begin
			obs_reg <= obs_next;
		end
	end

	// Raw value registers
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			raw_reg  <= '0;
			braw_reg <= '0;
		end else begin
			raw_reg  <= raw_next;
			braw_reg <= braw_next;
		end
	end

	// Outputs straight from their registers
	assign script_regs     = '{gain: gain_reg, bias: bias_reg, accel: sacc_reg, brake: sbrk_reg};
	assign obs             = obs_reg;
	assign accel_raw_cmd   = raw_reg;
	assign brake_raw_value = braw_reg;

endmodule

// ---- tb/tbc_path_chk.sv ----
`timescale 1ns/1ps
module tbc_path_chk (
	input wire logic                clk_sys,
	input wire logic                rst,
	input wire logic                tick,
	input wire logic                interlock_on,
	input wire logic                pump_mode,
	input wire logic                speed_mode,
	input wire logic                brake_path_on,
	input wire logic                wr_gain,
	input wire logic signed [15:0]  wr_data,
	input tbc_pkg::tbc_script_t     script_regs,
	input tbc_pkg::tbc_obs_t        obs
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// Reset leaves default gain and no request
	property p_rst; $fell(rst) |-> script_regs.gain == 16'sh0080 && obs.accel_cmd == 16'sh0000; endproperty
	a_rst: assert property (p_rst) else $error("reset values wrong");
	// Gain write lands one cycle later
	property p_gain; wr_gain |=> script_regs.gain == $past(wr_data); endproperty
	a_gain: assert property (p_gain) else $error("gain write lost");
	// Interlock off zeroes the request
	property p_lock; tick && !interlock_on |=> obs.accel_cmd == 16'sh0000; endproperty
	a_lock: assert property (p_lock) else $error("request without interlock");
	// Motor drive follows the request magnitude
	property p_drv; obs.motor_drive == (obs.accel_cmd > 16'sh0001 || obs.accel_cmd < 16'shffff); endproperty
	a_drv: assert property (p_drv) else $error("drive flag wrong");
	// Brake path off means no brake request
	property p_boff; tick && !brake_path_on |=> obs.brake_cmd == 16'sh0000; endproperty
	a_boff: assert property (p_boff) else $error("brake while path off");
	// Shaped brake never negative
	property p_bsat; !obs.shaped_brake[15]; endproperty
	a_bsat: assert property (p_bsat) else $error("brake below zero");
	// Brake overrides acceleration in speed modes
	property p_ovr; tick && speed_mode |=> obs.brake_cmd == 16'sh0000 || obs.accel_cmd == 16'sh0000; endproperty
	a_ovr: assert property (p_ovr) else $error("accel beside brake");
	// Pump mode never asks for reverse
	property p_pump; tick && pump_mode |=> !obs.accel_cmd[15]; endproperty
	a_pump: assert property (p_pump) else $error("reverse in pump mode");
endmodule
bind tbc_path tbc_path_chk u_chk (.*);

// ---- tb/tbc_script_eng.sv ----
`timescale 1ns/1ps
module tbc_script_eng (
	input wire logic                clk_sys,
	input wire logic                go,
	input wire logic [1:0]          sel,
	input wire logic signed [15:0]  din,
	output logic                    wr_gain,
	output logic                    wr_bias,
	output logic                    wr_accel,
	output logic                    wr_brake,
	output logic signed [15:0]      wr_data
);
	// Script writes leave as one-cycle strobes; idle data is scrambled
	always_ff @(posedge clk_sys) begin
		{wr_brake, wr_accel, wr_bias, wr_gain} <= go ? 4'h1 << sel : 4'h0;
		wr_data <= go ? din : ~wr_data;
	end
endmodule

// ---- tb/throttle_brake_command_path_tb_top.sv ----
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_total++; \
	$display("FAIL t=%0t got=%h exp=%h", $time, a, e); end end
module throttle_brake_command_path_tb_top;
	logic clk_sys, rst, tick, go, wr_gain, wr_bias, wr_accel, wr_brake, fwd_switch, rev_switch, pump_mode;
	logic interlock_on, fault_zero_accel, brake_path_on, speed_mode, accel_pot_setup, brake_pot_setup;
	logic [2:0] accel_type, brake_type;
	logic [11:0] accel_wiper_sample, brake_wiper_sample, pot_low_sample;
	logic [1:0] accel_wiring, brake_wiring, sel;
	logic [3:0] main_state;
	logic signed [15:0] accel_map_value, brake_map_value, wr_data, din, brake_raw_value;
	logic [15:0] accel_raw_cmd;
	tbc_pkg::tbc_script_t script_regs;
	tbc_pkg::tbc_obs_t obs;
	int err_total = 0;
	int checks = 0;
	int g[3] = '{256, 32767, -128};
	tbc_path dut (.*);
	tbc_script_eng u_eng (.*);
	initial begin
		clk_sys = 0;
		forever #50 clk_sys = ~clk_sys;
	end
	// Expected multiply-add with saturation and pump clamp
	function automatic logic signed [15:0] ex(int a, int gn, int b, bit p);
		int r;
		r = ((a * gn) >>> 7) + b;
		r = r > 32767 ? 32767 : (r < -32768 ? -32768 : r);
		return (p && r < 0) ? 16'sh0000 : 16'(r);
	endfunction
	task automatic wr(input logic [1:0] s, input logic signed [15:0] d);
		@(posedge clk_sys) begin go <= 1; sel <= s; din <= d; end
		@(posedge clk_sys) go <= 0;
		repeat (2) @(posedge clk_sys);
	endtask
	task automatic tk;
		@(posedge clk_sys) tick <= 1;
		@(posedge clk_sys) tick <= 0;
		@(posedge clk_sys);
		#1;
	endtask
	task automatic complete_run;
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		{rst, tick, go, fwd_switch, rev_switch, pump_mode, fault_zero_accel, brake_path_on, speed_mode} = 9'h100;
		{accel_pot_setup, brake_pot_setup, accel_wiper_sample, brake_wiper_sample, pot_low_sample} = '0;
		{accel_wiring, brake_wiring, sel, din, accel_map_value, brake_map_value} = '0;
		{interlock_on, main_state, accel_type, brake_type} = {1'h1, 4'h5, 3'h5, 3'h5};
		repeat (20) @(posedge clk_sys);
		rst <= 0;
		@(posedge clk_sys);
		#1;
		`CHK(script_regs.gain, 16'sh0080)
		wr(2'h2, 16'sh03e8);
		tk;
		`CHK(obs.accel_cmd, ex(1000, 128, 0, 0))
		foreach (g[i]) begin
			wr(2'h0, 16'(g[i]));
			wr(2'h1, -16'sh000a);
			tk;
			`CHK(obs.accel_cmd, ex(1000, g[i], -10, 0))
		end
		@(posedge clk_sys) pump_mode <= 1;
		tk;
		`CHK(obs.accel_cmd, ex(1000, -128, -10, 1))
		@(posedge clk_sys) begin pump_mode <= 0; main_state <= 4'h3; end
		tk;
		`CHK(obs.accel_cmd, 16'sh0000)
		@(posedge clk_sys) main_state <= 4'ha;
		tk;
		`CHK(obs.accel_cmd, ex(1000, -128, -10, 0))
		$display("accel script tests done");
		wr(2'h0, 16'sh0080);
		wr(2'h1, 16'sh0000);
		@(posedge clk_sys) begin accel_type <= 3'h1; fwd_switch <= 1; end
		tk;
		`CHK(obs.accel_cmd, 16'sh0001)
		`CHK(obs.motor_drive, 1'b0)
		@(posedge clk_sys) begin fwd_switch <= 0; rev_switch <= 1; end
		tk;
		`CHK(obs.accel_cmd, 16'shffff)
		@(posedge clk_sys) accel_map_value <= 16'sh01f4;
		tk;
		`CHK(obs.accel_cmd, 16'sh01f4)
		`CHK(obs.motor_drive, 1'b1)
		`CHK(obs.mapped_accel, 16'sh01f4)
		`CHK(obs.shaped_accel, 16'sh01f4)
		@(posedge clk_sys) interlock_on <= 0;
		tk;
		`CHK(obs.accel_cmd, 16'sh0000)
		`CHK(obs.shaped_accel, 16'sh01f4)
		@(posedge clk_sys) begin interlock_on <= 1; fault_zero_accel <= 1; end
		tk;
		`CHK(obs.accel_cmd, 16'sh0000)
		@(posedge clk_sys) fault_zero_accel <= 0;
		$display("accel mapped tests done");
		@(posedge clk_sys) brake_path_on <= 1;
		wr(2'h3, -16'sh0005);
		tk;
		`CHK(obs.brake_cmd, 16'sh0000)
		wr(2'h3, 16'sh02bc);
		@(posedge clk_sys) speed_mode <= 1;
		tk;
		`CHK(obs.brake_cmd, 16'sh02bc)
		`CHK(obs.shaped_brake, 16'sh02bc)
		`CHK(obs.accel_cmd, 16'sh0000)
		@(posedge clk_sys) begin brake_type <= 3'h2; brake_map_value <= 16'sh012c; end
		tk;
		`CHK(obs.brake_cmd, 16'sh012c)
		`CHK(obs.mapped_decel, 16'sh012c)
		@(posedge clk_sys) brake_path_on <= 0;
		tk;
		`CHK(obs.brake_cmd, 16'sh0000)
		$display("brake tests done");
		// Pot samples need two synchroniser cycles before the tick
		@(posedge clk_sys) begin accel_wiper_sample <= 12'h800; brake_wiper_sample <= 12'h400; brake_wiring <= 2'h1; end
		repeat (2) @(posedge clk_sys);
		tk;
		`CHK(accel_raw_cmd, 16'h4000)
		`CHK(obs.accel_pot_out, 16'h4000)
		`CHK(brake_raw_value, 16'sh5fff)
		`CHK(obs.brake_pot_out, 16'h5fff)
		@(posedge clk_sys) begin accel_wiring <= 2'h2; pot_low_sample <= 12'h400; accel_type <= 3'h5; end
		repeat (2) @(posedge clk_sys);
		tk;
		`CHK(obs.accel_pot_out, 16'h0000)
		`CHK(accel_raw_cmd, 16'h0000)
		@(posedge clk_sys) accel_pot_setup <= 1;
		tk;
		`CHK(obs.accel_pot_out, 16'h2000)
		$display("pot tests done");
		complete_run();
	end
	// Watchdog well beyond the roughly 150 cycles the tests need
	initial begin
		#(100 * 5000);
		err_total++;
		complete_run();
	end
endmodule
